//--- hdl/rci_pkg.sv
// constants for the reset and initialisation controller
// assumes one system clock and an axi4-lite register bus
package rci_pkg;
    localparam int unsigned CLK_HZ            = 10_000_000;
    localparam int unsigned LV_QUALIFY_NS     = 1000;   // low_voltage_qualify_time
    localparam int unsigned SW_RESET_DELAY_NS = 2000;   // software_reset_delay
    localparam int unsigned RESET_PULSE_NS    = 400;
    localparam int unsigned LV_QUALIFY_CYC =
        (LV_QUALIFY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned SW_RESET_CYC =
        (SW_RESET_DELAY_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned RESET_PULSE_CYC =
        (RESET_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned CNT_W = 8;

    // register byte offsets
    localparam logic [7:0] REG_FLAGS   = 8'h00;  // reset_cause_flags
    localparam logic [7:0] REG_WDCTL   = 8'h04;  // watchdog_control_register
    localparam logic [7:0] REG_STATUS  = 8'h08;  // timeout / power-down / cause
    localparam logic [7:0] REG_IRQ_ST  = 8'h0C;
    localparam logic [7:0] REG_IRQ_MSK = 8'h10;
    localparam logic [7:0] REG_MODE    = 8'h14;  // cpu mode: 0 run, 1 sleep/idle

    // field positions
    localparam int unsigned FLG_WDCFG = 0;
    localparam int unsigned FLG_LV    = 2;
    localparam int unsigned ST_TO     = 0;
    localparam int unsigned ST_PD     = 1;
    localparam int unsigned EN_LSB    = 3;

    localparam logic [7:0] WDCTL_RESET = 8'h53;
    localparam logic [4:0] WD_EN_A     = 5'h0A;
    localparam logic [4:0] WD_EN_B     = 5'h15;
    localparam logic [7:0] PORT_RESET  = 8'hFF;
    localparam logic [7:0] SP_TOP      = 8'h00;
    localparam logic [15:0] PC_RESET   = 16'h0000;

    typedef enum logic [2:0] {
        RCI_CAUSE_NONE, RCI_CAUSE_POR, RCI_CAUSE_LV, RCI_CAUSE_WD_RUN, RCI_CAUSE_WD_SLEEP,
        RCI_CAUSE_WD_CFG
    } rci_cause_t;

    typedef enum logic [1:0] { RCI_IDLE, RCI_HOLD } rci_state_t;
endpackage : rci_pkg

//--- hdl/rci_reset_ctrl.sv
// reset and initialisation controller: combines power-on, qualified low-voltage,
// watchdog time-out and watchdog configuration resets into core reset outputs.
// assumes rst is the power-on reset, inputs are synchronous to clk_sys.
module rci_reset_ctrl
    import rci_pkg::*;
(
    input  wire logic        clk_sys,        // system clock
    input  wire logic        rst,            // power-on reset, async high
    input  wire logic        supply_low,     // low-supply indication from monitor
    input  wire logic        wd_timeout,     // watchdog overflow pulse
    input  wire logic        halt_enter,     // halt executed: power-down set pulse
    input  wire logic        wd_clear,       // clear-watchdog instruction pulse
    output logic             core_reset,     // full reset to core and peripherals
    output logic             pc_sp_reset,    // program counter and stack pointer reset
    output logic [15:0]      pc_init,        // program counter load value
    output logic [7:0]       sp_init,        // stack pointer load value
    output logic [7:0]       port_init,      // port data/direction preset
    output logic             int_disable,    // all interrupt enables cleared
    output logic             timers_off,     // timer modules switched off
    output logic             wd_tb_clear,    // watchdog and time-base counters clear
    output logic [4:0]       wd_enable_field,// current watchdog enable code
    output logic [2:0]       wd_period_sel,  // watchdog period select
    output logic             irq,            // interrupt, high while unmasked event set
    input  wire logic [7:0]  s_axi_awaddr,   // write address
    input  wire logic        s_axi_awvalid,  // write address valid
    output logic             s_axi_awready,  // write address ready
    input  wire logic [31:0] s_axi_wdata,    // write data
    input  wire logic [3:0]  s_axi_wstrb,    // write strobes
    input  wire logic        s_axi_wvalid,   // write data valid
    output logic             s_axi_wready,   // write data ready
    output logic [1:0]       s_axi_bresp,    // write response
    output logic             s_axi_bvalid,   // write response valid
    input  wire logic        s_axi_bready,   // write response ready
    input  wire logic [7:0]  s_axi_araddr,   // read address
    input  wire logic        s_axi_arvalid,  // read address valid
    output logic             s_axi_arready,  // read address ready
    output logic [31:0]      s_axi_rdata,    // read data
    output logic [1:0]       s_axi_rresp,    // read response
    output logic             s_axi_rvalid,   // read data valid
    input  wire logic        s_axi_rready    // read data ready
);
    localparam logic [1:0] RESP_OK  = 2'b00;
    localparam logic [1:0] RESP_ERR = 2'b10;

    // bus state: one write and one read in flight at most
    logic        aw_have_q;
    logic        aw_have_d;
    logic        w_have_q;
    logic        w_have_d;
    logic        bvalid_q;
    logic        bvalid_d;
    logic [7:0]  awaddr_q;
    logic [7:0]  awaddr_d;
    logic [31:0] wdata_q;
    logic [31:0] wdata_d;
    logic        wstrb0_q;          // only byte lane 0 carries register bits
    logic        wstrb0_d;
    logic [1:0]  bresp_q;
    logic [1:0]  bresp_d;
    logic [1:0]  rresp_q;
    logic [1:0]  rresp_d;
    logic        rvalid_q;
    logic        rvalid_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // controller state
    logic        flag_lv_q;         // low_voltage_reset_flag
    logic        flag_lv_d;
    logic        flag_cfg_q;        // watchdog_config_reset_flag
    logic        flag_cfg_d;
    logic        to_q;              // watchdog_timeout_flag
    logic        to_d;
    logic        pd_q;              // power_down_flag
    logic        pd_d;
    logic [7:0]  wdctl_q;           // watchdog_control_register
    logic [7:0]  wdctl_d;
    logic        sleep_q;           // sleep or idle: low-voltage detection parked
    logic        sleep_d;
    logic [CNT_W-1:0] lv_cnt_q;     // consecutive low-supply cycles, saturating
    logic [CNT_W-1:0] lv_cnt_d;
    logic [CNT_W-1:0] cfg_cnt_q;    // software_reset_delay count
    logic [CNT_W-1:0] cfg_cnt_d;
    logic [CNT_W-1:0] hold_cnt_q;   // remaining full-reset hold cycles
    logic [CNT_W-1:0] hold_cnt_d;
    logic        cfg_pend_q;
    logic        cfg_pend_d;
    rci_state_t  state_q, state_d;
    rci_cause_t  cause_q, cause_d;
    logic [3:0]  ist_q;
    logic [3:0]  ist_d;
    logic [3:0]  imsk_q;
    logic [3:0]  imsk_d;
    logic        wd_sleep_q;        // one-cycle marker of a sleep watchdog wake

    // decoded events of the current cycle
    logic wr_fire;
    logic lv_qualified;
    logic cfg_fire;
    logic wd_run;
    logic wd_sleep;
    logic start_full;
    logic [7:0] rd_byte;
    logic rd_ok;

    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    // low voltage must persist; sleep disarms it, run modes keep it armed
    assign lv_qualified = !sleep_q && (lv_cnt_q == CNT_W'(LV_QUALIFY_CYC));
    assign cfg_fire     = cfg_pend_q && (cfg_cnt_q == CNT_W'(SW_RESET_CYC));
    assign wd_run       = wd_timeout && !sleep_q;
    assign wd_sleep     = wd_timeout && sleep_q;
    assign start_full   = lv_qualified || cfg_fire || wd_run;

    always_comb begin
        rd_ok = 1'b1;
        unique case (s_axi_araddr)
            REG_FLAGS:   rd_byte = {5'b0, flag_lv_q, 1'b0, flag_cfg_q};
            REG_WDCTL:   rd_byte = wdctl_q;
            REG_STATUS:  rd_byte = {3'b0, cause_q, pd_q, to_q};
            REG_IRQ_ST:  rd_byte = {4'b0, ist_q};
            REG_IRQ_MSK: rd_byte = {4'b0, imsk_q};
            REG_MODE:    rd_byte = {7'b0, sleep_q};
            default: begin
                rd_byte = 8'h00;
                rd_ok   = 1'b0;
            end
        endcase
    end

    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d  = w_have_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb0_d  = wstrb0_q;
        bvalid_d  = bvalid_q;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q;
        rresp_d   = rresp_q;
        rdata_d   = rdata_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb0_d = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_have_d = 1'b0;
            w_have_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = (awaddr_q <= REG_MODE && awaddr_q[1:0] == 2'b00) ? RESP_OK : RESP_ERR;
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rdata_d  = {24'h0, rd_byte};
            rresp_d  = rd_ok ? RESP_OK : RESP_ERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end

    always_comb begin
        logic wr_b;
        wr_b = wr_fire && wstrb0_q;
        flag_lv_d  = flag_lv_q;
        flag_cfg_d = flag_cfg_q;
        to_d       = to_q;
        pd_d       = pd_q;
        wdctl_d    = wdctl_q;
        sleep_d    = sleep_q;
        cfg_pend_d = cfg_pend_q;
        cfg_cnt_d  = cfg_cnt_q;
        hold_cnt_d = hold_cnt_q;
        state_d    = state_q;
        cause_d    = cause_q;
        imsk_d     = imsk_q;
        ist_d      = ist_q;
        lv_cnt_d   = (supply_low && !sleep_q && state_q == RCI_IDLE) ?
                     ((lv_cnt_q == CNT_W'(LV_QUALIFY_CYC)) ? lv_cnt_q : lv_cnt_q + 1'b1)
                     : '0;
        // software writes first so hardware sets below win over clears
        if (wr_b) begin
            unique case (awaddr_q)
                REG_FLAGS: begin
                    if (wdata_q[FLG_LV])    flag_lv_d  = 1'b0;
                    if (wdata_q[FLG_WDCFG]) flag_cfg_d = 1'b0;
                end
                REG_WDCTL: begin
                    wdctl_d = wdata_q[7:0];
                    if (wdata_q[7:EN_LSB] != WD_EN_A && wdata_q[7:EN_LSB] != WD_EN_B
                        && !cfg_pend_q) begin
                        cfg_pend_d = 1'b1;
                        cfg_cnt_d  = '0;
                    end
                end
                REG_STATUS: begin
                    if (wdata_q[ST_TO]) to_d = 1'b0;
                    if (wdata_q[ST_PD]) pd_d = 1'b0;
                end
                REG_IRQ_ST:  ist_d  = ist_q & ~wdata_q[3:0];
                REG_IRQ_MSK: imsk_d = wdata_q[3:0];
                REG_MODE:    sleep_d = wdata_q[0];
                default: ;
            endcase
        end
        if (halt_enter) begin
            pd_d    = 1'b1;
            sleep_d = 1'b1;
        end
        if (wd_clear) begin
            to_d = 1'b0;
            pd_d = 1'b0;
        end
        if (cfg_pend_q && !cfg_fire) cfg_cnt_d = cfg_cnt_q + 1'b1;
        if (state_q == RCI_HOLD) begin
            hold_cnt_d = hold_cnt_q - 1'b1;
            if (hold_cnt_q == CNT_W'(1)) state_d = RCI_IDLE;
        end
        // priority: low-voltage over watchdog sources
        if (start_full) begin
            state_d    = RCI_HOLD;
            hold_cnt_d = CNT_W'(RESET_PULSE_CYC);
            wdctl_d    = WDCTL_RESET;
            cfg_pend_d = 1'b0;
            sleep_d    = 1'b0;
            if (lv_qualified) begin
                flag_lv_d = 1'b1;
                cause_d   = RCI_CAUSE_LV;
                ist_d[0]  = 1'b1;
            end else if (cfg_fire) begin
                flag_cfg_d = 1'b1;
                cause_d    = RCI_CAUSE_WD_CFG;
                ist_d[1]   = 1'b1;
            end else begin
                to_d     = 1'b1;
                cause_d  = RCI_CAUSE_WD_RUN;
                ist_d[2] = 1'b1;
            end
        end else if (wd_sleep) begin
            to_d     = 1'b1;
            pd_d     = 1'b1;
            sleep_d  = 1'b0;
            cause_d  = RCI_CAUSE_WD_SLEEP;
            ist_d[3] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb0_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OK;
            rvalid_q  <= 1'b0;
            rresp_q   <= RESP_OK;
            rdata_q   <= '0;
            flag_lv_q  <= 1'b0;
            flag_cfg_q <= 1'b0;
            to_q       <= 1'b0;
            pd_q       <= 1'b0;
            wdctl_q    <= WDCTL_RESET;
            sleep_q    <= 1'b0;
            lv_cnt_q   <= '0;
            cfg_cnt_q  <= '0;
            cfg_pend_q <= 1'b0;
            hold_cnt_q <= CNT_W'(RESET_PULSE_CYC);
            state_q    <= RCI_HOLD;          // power-on outranks every source
            cause_q    <= RCI_CAUSE_POR;
            ist_q      <= '0;
            imsk_q     <= '0;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q  <= w_have_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb0_q  <= wstrb0_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            flag_lv_q  <= flag_lv_d;
            flag_cfg_q <= flag_cfg_d;
            to_q       <= to_d;
            pd_q       <= pd_d;
            wdctl_q    <= wdctl_d;
            sleep_q    <= sleep_d;
            lv_cnt_q   <= lv_cnt_d;
            cfg_cnt_q  <= cfg_cnt_d;
            cfg_pend_q <= cfg_pend_d;
            hold_cnt_q <= hold_cnt_d;
            state_q    <= state_d;
            cause_q    <= cause_d;
            ist_q      <= ist_d;
            imsk_q     <= imsk_d;
        end
    end

    // full reset held as a pulse; sleep watchdog touches only pc, sp and the watchdog/time-base clear
    assign core_reset  = rst || (state_q == RCI_HOLD);
    assign pc_sp_reset = core_reset || (cause_q == RCI_CAUSE_WD_SLEEP && ist_q[3]
                         && wd_sleep_q);
    assign pc_init     = PC_RESET;
    assign sp_init     = SP_TOP;
    assign port_init   = PORT_RESET;
    assign int_disable = core_reset;
    assign timers_off  = core_reset;
    assign wd_tb_clear = core_reset || pc_sp_reset; // released at once so counting resumes
    assign wd_enable_field = wdctl_q[7:EN_LSB];
    assign wd_period_sel   = wdctl_q[EN_LSB-1:0];
    assign irq = |(ist_q & imsk_q);

    // a full reset in the same cycle already covers pc and sp,
    // so the wake marker is only raised when no full reset starts
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wd_sleep_q <= 1'b0;
        end else begin
            wd_sleep_q <= wd_sleep && !start_full;
        end
    end
endmodule : rci_reset_ctrl

//--- tb/rci_assertions.sv
// concurrent checks on the reset controller ports
// assumes binding into rci_reset_ctrl; one clock, async rst
module rci_assertions
    import rci_pkg::*;
(
    input wire logic        clk_sys,      // clock
    input wire logic        rst,          // power-on
    input wire logic        supply_low,   // low supply
    input wire logic        wd_timeout,   // wd overflow
    input wire logic        halt_enter,   // halt
    input wire logic        core_reset,   // full reset
    input wire logic        pc_sp_reset,  // pc/sp reset
    input wire logic [15:0] pc_init,      // pc value
    input wire logic [7:0]  sp_init,      // sp value
    input wire logic [7:0]  port_init,    // port preset
    input wire logic        int_disable,  // irq off
    input wire logic        timers_off,   // timers off
    input wire logic        wd_tb_clear,  // wd clear
    input wire logic        s_axi_bvalid, // b valid
    input wire logic        s_axi_bready  // b ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] lv_run_q, lv_run_d;
    logic       sleep_q, sleep_d;
    // sleep tracked from pulses only; a bus write to the mode bit is not seen here
    always_comb begin
        lv_run_d = supply_low ? lv_run_q + {3'h0, lv_run_q != 4'hF} : 4'h0;
        sleep_d  = (sleep_q | halt_enter) & ~wd_timeout & ~core_reset;
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lv_run_q <= 4'h0;
            sleep_q  <= 1'b0;
        end else begin
            lv_run_q <= lv_run_d;
            sleep_q  <= sleep_d;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence lv_qual_s; supply_low && lv_run_q == 4'h9 && !sleep_q; endsequence
    sequence sleep_wd_s; sleep_q && wd_timeout; endsequence
    lv_reset_a: assert property (lv_qual_s |-> ##[1:4] core_reset)
        else $error("qualified low supply gave no reset");
    sleep_wake_a: assert property (sleep_wd_s |=> pc_sp_reset && !core_reset)
        else $error("sleep watchdog wake wrong");
    run_wd_a: assert property (!sleep_q && wd_timeout && !core_reset |-> ##[1:3] core_reset)
        else $error("run watchdog gave no reset");
    pc_sp_zero_a: assert property (pc_sp_reset |-> pc_init == PC_RESET && sp_init == SP_TOP)
        else $error("pc or sp load value wrong");
    port_ones_a: assert property (core_reset |-> port_init == 8'hFF && pc_sp_reset)
        else $error("port preset wrong");
    irq_timer_a: assert property (int_disable == core_reset && timers_off == core_reset)
        else $error("interrupt or timer off wrong");
    wd_clear_a: assert property (wd_tb_clear == (core_reset | pc_sp_reset))
        else $error("watchdog clear wrong");
    por_hold_a: assert property ($fell(rst) |-> core_reset [*3])
        else $error("power-on hold too short");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
endmodule : rci_assertions

//--- tb/rci_core_model.sv
// core side model: supply monitor, watchdog and cpu event pulses
// assumes the bench calls its tasks; counts resets the core receives
module rci_core_model (
    input  wire logic clk_sys,     // clock
    input  wire logic core_reset,  // full reset
    input  wire logic pc_sp_reset, // pc/sp reset
    output logic      supply_low,  // low supply
    output logic      wd_timeout,  // wd overflow
    output logic      halt_enter,  // halt
    output logic      wd_clear,    // clear wd
    output int        n_full,      // full resets
    output int        n_pcsp       // pc/sp-only resets
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev_full = 1'b0;
    logic prev_pcsp = 1'b0;
    initial begin
        {supply_low, wd_timeout, halt_enter, wd_clear} = 4'h0;
        n_full = 0;
        n_pcsp = 0;
    end
    always @(posedge clk_sys) begin
        if (core_reset && !prev_full) n_full <= n_full + 1;
        if (pc_sp_reset && !core_reset && !prev_pcsp) n_pcsp <= n_pcsp + 1;
        prev_full <= core_reset;
        prev_pcsp <= pc_sp_reset;
    end
    // supply held low for n sampled edges
    task automatic low_supply(input int n);
        @(posedge clk_sys);
        supply_low <= 1'b1;
        repeat (n) @(posedge clk_sys);
        supply_low <= 1'b0;
    endtask : low_supply
    // one-cycle pulse: 0 watchdog overflow, 1 halt, 2 clear watchdog
    task automatic pulse(input int k);
        @(posedge clk_sys);
        {wd_clear, halt_enter, wd_timeout} <= 3'(1 << k);
        @(posedge clk_sys);
        {wd_clear, halt_enter, wd_timeout} <= 3'h0;
    endtask : pulse
endmodule : rci_core_model

//--- tb/tb_rci_reset_ctrl.sv
// self-checking bench for the reset and initialisation controller
// assumes rci_pkg and rci_reset_ctrl compiled before it
module tb_rci_reset_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} rci_row_t;
    logic clk_sys = 1'b0, rst = 1'b1, supply_low, wd_timeout, halt_enter, wd_clear;
    logic core_reset, pc_sp_reset, int_disable, timers_off, wd_tb_clear, irq;
    logic [15:0] pc_init;
    logic [7:0] sp_init, port_init, s_axi_awaddr, s_axi_araddr;
    logic [4:0] wd_enable_field;
    logic [2:0] wd_period_sel;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    int miscompares = 0, n_compared = 0, n_full, n_pcsp;
    rci_row_t rows [7] = '{'{8'h00, 32'h0000_0000, 2'b00}, '{8'h04, 32'h0000_0053, 2'b00},
        '{8'h08, 32'h0000_0004, 2'b00}, '{8'h0C, 32'h0000_0000, 2'b00},
        '{8'h14, 32'h0000_0000, 2'b00}, '{8'h18, 32'h0000_0000, 2'b10},
        '{8'h02, 32'h0000_0000, 2'b10}};
    always #50 clk_sys = ~clk_sys;
    rci_reset_ctrl u_rci_reset_ctrl (.clk_sys, .rst, .supply_low, .wd_timeout, .halt_enter,
        .wd_clear, .core_reset, .pc_sp_reset, .pc_init, .sp_init, .port_init, .int_disable,
        .timers_off, .wd_tb_clear, .wd_enable_field, .wd_period_sel, .irq, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    rci_core_model u_rci_core_model (.clk_sys, .core_reset, .pc_sp_reset, .supply_low,
        .wd_timeout, .halt_enter, .wd_clear, .n_full, .n_pcsp);
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    task automatic tmo;
        miscompares++;
        print_verdict;
    endtask : tmo
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        s_axi_bready <= 1'b0;
        if (s_axi_bvalid !== 1'b1) tmo;
        chk("bresp", 32'h0000_0000, 32'(s_axi_bresp));
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        int n;
        n = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk_sys);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 40);
        {rd_d, rd_r} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'b0;
        if (s_axi_rvalid !== 1'b1) tmo;
        chk("rdata", e, rd_d);
    endtask : rd
    // waits out the reset hold, bounded
    task automatic settle;
        int n;
        n = 0;
        repeat (4) @(posedge clk_sys);
        while (core_reset !== 1'b0 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        if (core_reset !== 1'b0) tmo;
    endtask : settle
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        settle;
        chk("period", 32'h0000_0003, 32'(wd_period_sel));
        foreach (rows[i]) begin
            rd(rows[i].a, rows[i].d);
            chk("rresp", 32'(rows[i].r), 32'(rd_r));
        end
        chk("enable", 32'h0000_000A, 32'(wd_enable_field));
        u_rci_core_model.low_supply(5);
        repeat (6) @(posedge clk_sys);
        chk("resets", 32'h0000_0001, 32'(n_full));
        u_rci_core_model.low_supply(12);
        settle;
        chk("resets", 32'h0000_0002, 32'(n_full));
        rd(8'h00, 32'h0000_0004);
        rd(8'h08, 32'h0000_0008);
        wr(8'h00, 32'h0000_00FF);
        rd(8'h00, 32'h0000_0000);
        u_rci_core_model.pulse(1);
        rd(8'h08, 32'h0000_000A);
        u_rci_core_model.low_supply(12);
        repeat (6) @(posedge clk_sys);
        chk("resets", 32'h0000_0002, 32'(n_full));
        u_rci_core_model.pulse(0);
        settle;
        chk("wakes", 32'h0000_0001, 32'(n_pcsp));
        rd(8'h08, 32'h0000_0013);
        u_rci_core_model.low_supply(12);
        settle;
        rd(8'h08, 32'h0000_000B);
        u_rci_core_model.pulse(0);
        settle;
        chk("resets", 32'h0000_0004, 32'(n_full));
        rd(8'h08, 32'h0000_000F);
        u_rci_core_model.pulse(2);
        rd(8'h08, 32'h0000_000C);
        wr(8'h0C, 32'h0000_000F);
        wr(8'h04, 32'h0000_00A8);
        repeat (6) @(posedge clk_sys);
        chk("enable", 32'h0000_0015, 32'(wd_enable_field));
        chk("resets", 32'h0000_0004, 32'(n_full));
        wr(8'h04, 32'h0000_0000);
        repeat (rci_pkg::SW_RESET_CYC - 2) @(posedge clk_sys);
        chk("resets", 32'h0000_0004, 32'(n_full));
        settle;
        chk("resets", 32'h0000_0005, 32'(n_full));
        rd(8'h00, 32'h0000_0005);
        rd(8'h04, 32'h0000_0053);
        rd(8'h0C, 32'h0000_0002);
        chk("irq", 32'h0000_0000, 32'(irq));
        s_axi_wstrb <= 4'h0;
        wr(8'h10, 32'h0000_000F);
        s_axi_wstrb <= 4'h1;
        rd(8'h10, 32'h0000_0000);
        chk("irq", 32'h0000_0000, 32'(irq));
        wr(8'h10, 32'h0000_0002);
        chk("irq", 32'h0000_0001, 32'(irq));
        wr(8'h0C, 32'h0000_0002);
        chk("irq", 32'h0000_0000, 32'(irq));
        // second power-on mid-run with the flags set
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        settle;
        rd(8'h08, 32'h0000_0004);
        rd(8'h00, 32'h0000_0000);
        print_verdict;
    end
endmodule : tb_rci_reset_ctrl
bind rci_reset_ctrl rci_assertions u_rci_assertions (.clk_sys, .rst, .supply_low, .wd_timeout,
    .halt_enter, .core_reset, .pc_sp_reset, .pc_init, .sp_init, .port_init, .int_disable,
    .timers_off, .wd_tb_clear, .s_axi_bvalid, .s_axi_bready);
